// ===== low_overlay_fetch_key.sv
// Overlay window fetch, colour key merge and its overlay word FIFO
// Contract
// R1 - The key is held as separate 6-bit red, green and blue fields.
// R2 - An overlay pixel equal to the key is replaced by the background pixel.
// R3 - In 24bpp mode a key match needs the top two bits of each channel zero.
// R4 - With the window at (0,0) or (1,0) the first overlay word is sent second.
// R5 - In that placement the leftmost overlay pixel is the buffer's last word.
// R6 - Fetch address bits 31 to 22 stay fixed for each plane's picture.
// R7 - An incrementing fetch address wraps within its 4MB region.
// R8 - Software places the overlay image from the region at 0x2000_0000.
// R9 - Software avoids (0,0) and (1,0) or pre-rotates the overlay data.
// R10 - Each slot emits one pixel, from overlay or background as placed.
`timescale 1ns/1ps

// ============================================================
// Overlay word FIFO
module low_fifo #(
    parameter int W = 32,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_clr,
    // Fill side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [W-1:0] i_in_data,
    // Drain side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [W-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] cnt_reg;
    logic push;
    logic pop;

    // Full and empty straight from the occupancy count
    assign o_in_ready = (cnt_reg != (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_reg != '0);
    assign o_out_data = mem[rd_ptr_reg];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    // Storage has no reset; only pointers and count need a defined value
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= i_in_data;
        end
    end

    // Pointers and count; clear discards leftovers of a frame
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg <= '0;
        end else if (i_clr) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
            end
            if (pop) begin
                rd_ptr_reg <= AW'(rd_ptr_reg + 1'b1);
            end
            if (push && !pop) begin
                cnt_reg <= (AW+1)'(cnt_reg + 1'b1);
            end else if (pop && !push) begin
                cnt_reg <= (AW+1)'(cnt_reg - 1'b1);
            end
        end
    end
endmodule : low_fifo

// ============================================================
// Top: registers, fetch engines, merge and pixel stream
module low_overlay_fetch_key #(
    parameter logic [10:0] H_ACTIVE = 11'd320,
    parameter logic [10:0] V_ACTIVE = 11'd240,
    parameter int FIFO_DEPTH = 16
) (
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RST,
    // Register port
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [31:0] I_REG_WDATA,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    output logic [31:0] O_REG_RDATA,
    // Background plane fetch
    output logic O_BG_REQ,
    output logic [31:0] O_BG_ADDR,
    input wire logic I_BG_ACK,
    input wire logic [31:0] I_BG_DATA,
    // Overlay window fetch
    output logic O_OV_REQ,
    output logic [31:0] O_OV_ADDR,
    input wire logic I_OV_ACK,
    input wire logic [31:0] I_OV_DATA,
    // Pixel stream to the panel
    output logic O_PIX_VALID,
    input wire logic I_PIX_READY,
    output logic [23:0] O_PIX_DATA,
    output logic O_PIX_SOF
);
    low_pkg::low_state_e state_reg;
    logic enable_reg;
    logic mode24_reg;
    logic ov_en_reg;
    logic [5:0] overlay_key_red;
    logic [5:0] overlay_key_green;
    logic [5:0] overlay_key_blue;
    logic [10:0] win_x_reg;
    logic [10:0] win_y_reg;
    logic [10:0] win_w_reg;
    logic [10:0] win_h_reg;
    logic [31:0] bg_base_reg;
    logic [31:0] ov_base_reg;
    logic [10:0] x_reg;
    logic [10:0] y_reg;
    logic [21:0] bg_off_reg;
    logic [21:0] ov_off_reg;
    logic [21:0] ov_cnt_reg;
    logic [23:0] bg_pix_reg;
    logic [23:0] pix_reg;
    logic sof_reg;
    logic [31:0] rdata_reg;
    logic frame_load;
    logic last_pix;
    logic in_win;
    logic shifted;
    logic [21:0] ov_total;
    logic [21:0] ov_last;
    logic ff_in_ready;
    logic ff_out_valid;
    logic ff_out_ready;
    logic [31:0] ff_out_data;
    logic key_hit;
    logic [11:0] x_end;
    logic [11:0] y_end;

    // ============================================================
    // Register writes; key fields are 6 bits wide
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            enable_reg <= 1'b0;
            mode24_reg <= 1'b0;
            ov_en_reg <= 1'b0;
            overlay_key_red <= '0;
            overlay_key_green <= '0;
            overlay_key_blue <= '0;
            win_x_reg <= '0;
            win_y_reg <= '0;
            win_w_reg <= '0;
            win_h_reg <= '0;
            bg_base_reg <= low_pkg::RST_REG;
            ov_base_reg <= low_pkg::RST_REG;
        end else if (I_REG_WR) begin
            case (I_REG_ADDR)
                low_pkg::OFS_CTRL: begin
                    enable_reg <= I_REG_WDATA[low_pkg::CTRL_EN];
                    mode24_reg <= I_REG_WDATA[low_pkg::CTRL_M24];
                end
                low_pkg::OFS_OVCTL: begin // R1
                    overlay_key_red <= I_REG_WDATA[low_pkg::OV_KEY_R+:6];
                    overlay_key_green <= I_REG_WDATA[low_pkg::OV_KEY_G+:6];
                    overlay_key_blue <= I_REG_WDATA[low_pkg::OV_KEY_B+:6];
                    ov_en_reg <= I_REG_WDATA[low_pkg::OV_EN];
                end
                low_pkg::OFS_WPOS: begin
                    win_x_reg <= I_REG_WDATA[10:0];
                    win_y_reg <= I_REG_WDATA[low_pkg::POS_Y+:11];
                end
                low_pkg::OFS_WSIZE: begin
                    win_w_reg <= I_REG_WDATA[10:0];
                    win_h_reg <= I_REG_WDATA[low_pkg::POS_Y+:11];
                end
                low_pkg::OFS_BGBASE: bg_base_reg <= I_REG_WDATA;
                low_pkg::OFS_OVBASE: ov_base_reg <= I_REG_WDATA;
                default: ;
            endcase
        end
    end

    // Read data stands one cycle after the strobe; unmapped reads zero
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= '0;
            if (I_REG_RD) begin
                case (I_REG_ADDR)
                    low_pkg::OFS_CTRL: begin
                        rdata_reg[low_pkg::CTRL_EN] <= enable_reg;
                        rdata_reg[low_pkg::CTRL_M24] <= mode24_reg;
                    end
                    low_pkg::OFS_OVCTL: begin
                        rdata_reg[low_pkg::OV_KEY_R+:6] <= overlay_key_red;
                        rdata_reg[low_pkg::OV_KEY_G+:6] <= overlay_key_green;
                        rdata_reg[low_pkg::OV_KEY_B+:6] <= overlay_key_blue;
                        rdata_reg[low_pkg::OV_EN] <= ov_en_reg;
                    end
                    low_pkg::OFS_WPOS:
                        rdata_reg <= {5'h00, win_y_reg, 5'h00, win_x_reg};
                    low_pkg::OFS_WSIZE:
                        rdata_reg <= {5'h00, win_h_reg, 5'h00, win_w_reg};
                    low_pkg::OFS_BGBASE: rdata_reg <= bg_base_reg;
                    low_pkg::OFS_OVBASE: rdata_reg <= ov_base_reg;
                    low_pkg::OFS_STAT: begin
                        rdata_reg[0] <= (state_reg != low_pkg::ST_IDLE);
                        rdata_reg[1] <= !ff_out_valid;
                        rdata_reg[2] <= !ff_in_ready;
                        rdata_reg[3] <= shifted;
                        rdata_reg[low_pkg::ST_LINE+:11] <= y_reg;
                    end
                    default: rdata_reg <= '0;
                endcase
            end
        end
    end
    assign O_REG_RDATA = rdata_reg;

    // ============================================================
    // Window geometry; origin at (0,0) or (1,0) enters shifted mode
    assign x_end = {1'b0, win_x_reg} + {1'b0, win_w_reg};
    assign y_end = {1'b0, win_y_reg} + {1'b0, win_h_reg};
    assign in_win = ov_en_reg && ({1'b0, x_reg} >= {1'b0, win_x_reg})
        && ({1'b0, x_reg} < x_end) && ({1'b0, y_reg} >= {1'b0, win_y_reg})
        && ({1'b0, y_reg} < y_end);
    assign shifted = ov_en_reg && (win_x_reg <= 11'd1)
        && (win_y_reg == 11'd0); // R4
    assign ov_total = 22'(win_w_reg * win_h_reg);
    assign ov_last = 22'(ov_base_reg[21:0] + 22'((ov_total - 1'b1) << 2));
    assign last_pix = (x_reg == H_ACTIVE - 1'b1)
        && (y_reg == V_ACTIVE - 1'b1);
    assign frame_load = ((state_reg == low_pkg::ST_IDLE) && enable_reg)
        || ((state_reg == low_pkg::ST_EMIT) && I_PIX_READY && last_pix);

    // ============================================================
    // Fetch addresses keep the region bits and wrap the low 22 bits
    assign O_BG_REQ = (state_reg == low_pkg::ST_FETCH);
    assign O_BG_ADDR = {bg_base_reg[31:low_pkg::REGION_LSB],
        bg_off_reg}; // R6
    assign O_OV_REQ = (state_reg != low_pkg::ST_IDLE) && ov_en_reg
        && !frame_load && ff_in_ready && (ov_cnt_reg < ov_total);
    // Shifted mode fetches the last word first, then from the start
    assign O_OV_ADDR = {ov_base_reg[31:low_pkg::REGION_LSB],
        (shifted && ov_cnt_reg == '0) ? ov_last : ov_off_reg}; // R5 R6

    // Offset counters; 22-bit arithmetic cannot carry upward
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            bg_off_reg <= '0;
            ov_off_reg <= '0;
            ov_cnt_reg <= '0;
        end else if (frame_load) begin
            bg_off_reg <= bg_base_reg[21:0];
            ov_off_reg <= ov_base_reg[21:0];
            ov_cnt_reg <= '0;
        end else begin
            if (O_BG_REQ && I_BG_ACK) begin
                bg_off_reg <= 22'(bg_off_reg + low_pkg::WORD_STEP); // R7
            end
            if (O_OV_REQ && I_OV_ACK) begin
                ov_cnt_reg <= 22'(ov_cnt_reg + 1'b1);
                if (!(shifted && ov_cnt_reg == '0)) begin
                    ov_off_reg <= 22'(ov_off_reg + low_pkg::WORD_STEP); // R7
                end
            end
        end
    end

    // Overlay words queue here; a full FIFO holds off further fetches
    low_fifo #(
        .W(32),
        .DEPTH(FIFO_DEPTH)
    ) u_ov_fifo (
        .i_clk(I_CLOCK),
        .i_rst(I_RST),
        .i_clr(frame_load),
        .i_in_valid(O_OV_REQ && I_OV_ACK),
        .o_in_ready(ff_in_ready),
        .i_in_data(I_OV_DATA),
        .o_out_valid(ff_out_valid),
        .i_out_ready(ff_out_ready),
        .o_out_data(ff_out_data)
    );
    assign ff_out_ready = (state_reg == low_pkg::ST_MERGE) && in_win;

    // ============================================================
    // Key compare; 24bpp needs the two top bits of each channel clear
    always_comb begin
        if (mode24_reg) begin
            key_hit = (ff_out_data[23:22] == 2'b00)
                && (ff_out_data[15:14] == 2'b00)
                && (ff_out_data[7:6] == 2'b00)
                && (ff_out_data[21:16] == overlay_key_red)
                && (ff_out_data[13:8] == overlay_key_green)
                && (ff_out_data[5:0] == overlay_key_blue); // R3
        end else begin
            key_hit = (ff_out_data[23:18] == overlay_key_red)
                && (ff_out_data[15:10] == overlay_key_green)
                && (ff_out_data[7:2] == overlay_key_blue);
        end
    end

    // ============================================================
    // Pixel sequencer: fetch background, merge overlay, emit
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            state_reg <= low_pkg::ST_IDLE;
        end else begin
            case (state_reg)
                low_pkg::ST_IDLE:
                    if (enable_reg) state_reg <= low_pkg::ST_FETCH;
                low_pkg::ST_FETCH:
                    if (I_BG_ACK) state_reg <= low_pkg::ST_MERGE;
                low_pkg::ST_MERGE:
                    if (!in_win || ff_out_valid) begin
                        state_reg <= low_pkg::ST_EMIT;
                    end
                low_pkg::ST_EMIT:
                    if (I_PIX_READY) begin // R10
                        state_reg <= (last_pix && !enable_reg)
                            ? low_pkg::ST_IDLE : low_pkg::ST_FETCH;
                    end
                default: state_reg <= low_pkg::ST_IDLE;
            endcase
        end
    end

    // Raster position advances once per accepted pixel
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            x_reg <= '0;
            y_reg <= '0;
        end else if (frame_load) begin
            x_reg <= '0;
            y_reg <= '0;
        end else if (state_reg == low_pkg::ST_EMIT && I_PIX_READY) begin
            if (x_reg == H_ACTIVE - 1'b1) begin
                x_reg <= '0;
                y_reg <= 11'(y_reg + 1'b1);
            end else begin
                x_reg <= 11'(x_reg + 1'b1);
            end
        end
    end

    // Pixel data registers; keyed overlay shows the background
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            bg_pix_reg <= '0;
            pix_reg <= '0;
            sof_reg <= 1'b0;
        end else begin
            if (state_reg == low_pkg::ST_FETCH && I_BG_ACK) begin
                bg_pix_reg <= I_BG_DATA[23:0];
            end
            if (state_reg == low_pkg::ST_MERGE) begin
                sof_reg <= (x_reg == '0) && (y_reg == '0);
                if (!in_win) begin
                    pix_reg <= bg_pix_reg; // R10
                end else if (ff_out_valid) begin
                    pix_reg <= key_hit ? bg_pix_reg
                        : ff_out_data[23:0]; // R2 R10
                end
            end
        end
    end
    assign O_PIX_VALID = (state_reg == low_pkg::ST_EMIT);
    assign O_PIX_DATA = pix_reg;
    assign O_PIX_SOF = sof_reg && O_PIX_VALID;

    // ============================================================
    // Checks
    sequence s_key_merge;
        state_reg == low_pkg::ST_MERGE && in_win && ff_out_valid && key_hit;
    endsequence
    property p_key_replace;
        @(posedge I_CLOCK) disable iff (I_RST)
        s_key_merge |=> O_PIX_VALID && O_PIX_DATA == $past(bg_pix_reg);
    endproperty
    a_key_replace: assert property (p_key_replace) // R2
        else $error("Keyed overlay pixel not replaced by background");

    property p_key_width;
        @(posedge I_CLOCK) disable iff (I_RST)
        I_REG_RD && I_REG_ADDR == low_pkg::OFS_OVCTL
            |=> O_REG_RDATA[7:6] == 2'b00 && O_REG_RDATA[15:14] == 2'b00;
    endproperty
    a_key_width: assert property (p_key_width) // R1
        else $error("Key field wider than six bits");

    property p_m24_top;
        @(posedge I_CLOCK) disable iff (I_RST)
        mode24_reg && key_hit |-> ff_out_data[23:22] == 2'b00
            && ff_out_data[15:14] == 2'b00 && ff_out_data[7:6] == 2'b00;
    endproperty
    a_m24_top: assert property (p_m24_top) // R3
        else $error("24bpp key hit with high channel bits set");

    property p_shift_second;
        @(posedge I_CLOCK) disable iff (I_RST)
        O_OV_REQ && shifted && ov_cnt_reg == 22'd1
            |-> O_OV_ADDR[21:0] == ov_base_reg[21:0];
    endproperty
    a_shift_second: assert property (p_shift_second) // R4
        else $error("First overlay word not fetched second");

    property p_shift_last;
        @(posedge I_CLOCK) disable iff (I_RST)
        O_OV_REQ && shifted && ov_cnt_reg == '0
            |-> O_OV_ADDR[21:0] == ov_last;
    endproperty
    a_shift_last: assert property (p_shift_last) // R5
        else $error("Shifted window does not lead with last word");

    property p_region;
        @(posedge I_CLOCK) disable iff (I_RST)
        O_OV_REQ |-> O_OV_ADDR[31:22] == ov_base_reg[31:22];
    endproperty
    a_region: assert property (p_region) // R6
        else $error("Overlay fetch left its 4MB region");

    property p_wrap;
        @(posedge I_CLOCK) disable iff (I_RST)
        O_BG_REQ && I_BG_ACK && !frame_load && bg_off_reg == 22'h3ffffc
            |=> bg_off_reg == '0
            && O_BG_ADDR[31:22] == $past(bg_base_reg[31:22]);
    endproperty
    a_wrap: assert property (p_wrap) // R7
        else $error("Background fetch address did not wrap");

    sequence s_emit_taken;
        O_PIX_VALID && I_PIX_READY;
    endsequence
    property p_one_per_slot;
        @(posedge I_CLOCK) disable iff (I_RST)
        s_emit_taken |=> !O_PIX_VALID;
    endproperty
    a_one_per_slot: assert property (p_one_per_slot) // R10
        else $error("More than one pixel per slot");

    property p_outside;
        @(posedge I_CLOCK) disable iff (I_RST)
        state_reg == low_pkg::ST_MERGE && !in_win
            |=> O_PIX_DATA == $past(bg_pix_reg);
    endproperty
    a_outside: assert property (p_outside) // R10
        else $error("Pixel outside window not from background");
endmodule : low_overlay_fetch_key

// ===== low_pkg.sv
// Package: register map and constants of the overlay fetch and key block
package low_pkg;
    // ============================================================
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_OVCTL = 8'h04;
    localparam logic [7:0] OFS_WPOS = 8'h08;
    localparam logic [7:0] OFS_WSIZE = 8'h0c;
    localparam logic [7:0] OFS_BGBASE = 8'h10;
    localparam logic [7:0] OFS_OVBASE = 8'h14;
    localparam logic [7:0] OFS_STAT = 8'h18;
    // ============================================================
    // Field positions
    localparam int CTRL_EN = 0;
    localparam int CTRL_M24 = 1;
    localparam int OV_KEY_B = 0;
    localparam int OV_KEY_G = 8;
    localparam int OV_KEY_R = 16;
    localparam int OV_EN = 31;
    localparam int POS_Y = 16;
    localparam int KEY_W = 6;
    localparam int COORD_W = 11;
    localparam int REGION_LSB = 22;
    localparam int ST_LINE = 16;
    // ============================================================
    // Reset values and fetch step
    localparam logic [31:0] RST_REG = 32'h0000_0000;
    localparam logic [21:0] WORD_STEP = 22'h00_0004;
    // ============================================================
    // Pixel sequencer states, Gray on every step except ST_EMIT back to ST_FETCH
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FETCH = 2'b01,
        ST_MERGE = 2'b11,
        ST_EMIT = 2'b10
    } low_state_e;
endpackage : low_pkg

// ===== low_panel_model.sv
// Panel model: sink of the pixel stream with random stalls
`timescale 1ns/1ps
// ============================================================
// Pixel sink
module low_panel_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Pixel stream
    input wire logic i_valid,
    output logic o_ready
);
    // Stalls only the cycle after valid was seen, so a pixel after an idle cycle is never held
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_ready <= 1'b0;
        end else begin
            o_ready <= !i_valid || (($urandom % 3) != 0);
        end
    end
endmodule : low_panel_model

// ===== tb_top.sv
// Testbench: random frames through the overlay fetch and key block
`timescale 1ns/1ps
module tb_top;
    localparam logic [10:0] HA = 11'd8;
    localparam logic [10:0] VA = 11'd4;
    localparam int NPIX = 32;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic bg_ack = 1'b0;
    logic ov_ack = 1'b0;
    logic [31:0] bg_data = 32'h0;
    logic [31:0] ov_data = 32'h0;
    logic [31:0] rdata, bg_addr, ov_addr;
    logic bg_req, ov_req, pix_valid, pix_sof, pix_ready;
    logic [23:0] pix_data;
    logic [31:0] bg_base = 32'h0;
    logic [31:0] ov_base = 32'h0;
    logic [10:0] x0 = 11'h0;
    logic [10:0] y0 = 11'h0;
    logic [10:0] ww = 11'h1;
    logic [10:0] hh = 11'h1;
    logic [5:0] kr = 6'h0;
    logic [5:0] kg = 6'h0;
    logic [5:0] kb = 6'h0;
    logic m24 = 1'b0;
    int n_mismatch = 0;
    int total_checks = 0;
    int n_pix = 0;
    int ov_k = 0;
    int sh, seed;
    low_overlay_fetch_key #(
        .H_ACTIVE(HA),
        .V_ACTIVE(VA)
    ) u_low_overlay_fetch_key (
        .I_CLOCK(clk), .I_RST(rst), .I_REG_ADDR(addr), .I_REG_WDATA(wdata),
        .I_REG_WR(reg_wr), .I_REG_RD(reg_rd), .O_REG_RDATA(rdata),
        .O_BG_REQ(bg_req), .O_BG_ADDR(bg_addr), .I_BG_ACK(bg_ack),
        .I_BG_DATA(bg_data), .O_OV_REQ(ov_req), .O_OV_ADDR(ov_addr),
        .I_OV_ACK(ov_ack), .I_OV_DATA(ov_data), .O_PIX_VALID(pix_valid),
        .I_PIX_READY(pix_ready), .O_PIX_DATA(pix_data), .O_PIX_SOF(pix_sof));
    low_panel_model u_low_panel_model (.i_clk(clk), .i_rst(rst),
        .i_valid(pix_valid), .o_ready(pix_ready));
    // ============================================================
    // Expectation functions
    function automatic logic [23:0] key_pix();
        if (m24) return {2'b00, kr, 2'b00, kg, 2'b00, kb};
        return {kr, 2'b01, kg, 2'b10, kb, 2'b11};
    endfunction : key_pix
    // Word at a: the key, a near miss with the top bit flipped, or a hash
    function automatic logic [31:0] mem(input logic [31:0] a);
        case (a[3:2])
            2'd0: return {8'h00, key_pix()};
            2'd1: return {8'h00, key_pix() ^ 24'h800000};
            default: return {8'h00, a[9:2], ~a[9:2], a[9:2] ^ 8'h5a};
        endcase
    endfunction : mem
    function automatic logic is_key(input logic [23:0] p);
        if (m24) return p == key_pix();
        return {p[23:18], p[15:10], p[7:2]} == {kr, kg, kb};
    endfunction : is_key
    // Upper ten bits never carry
    function automatic logic [31:0] wa(input logic [31:0] b, input int i);
        return {b[31:22], b[21:0] + 22'(i * 4)};
    endfunction : wa
    function automatic logic [23:0] exp_pix(input int n);
        int x, y, idx;
        logic [31:0] ov;
        x = n % int'(HA);
        y = n / int'(HA);
        ov = mem(wa(bg_base, n));
        if (x < x0 || x >= x0 + ww || y < y0 || y >= y0 + hh) return ov[23:0];
        idx = (y - y0) * ww + x - x0;
        if (sh != 0) idx = (idx + ww * hh - 1) % (ww * hh);
        ov = mem(wa(ov_base, idx));
        if (is_key(ov[23:0])) ov = mem(wa(bg_base, n));
        return ov[23:0];
    endfunction : exp_pix
    task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
        total_checks++;
        if (e !== g) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // ============================================================
    // Register bus tasks and the end-of-run report
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk("register read", e, rdata);
    endtask : rd_chk
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : close_out
    // ============================================================
    // One frame with a random key, mode and window size
    task automatic frame(input logic [10:0] px, input logic [10:0] py);
        int t;
        m24 = 1'($urandom);
        {kr, kg, kb} = 18'($urandom);
        x0 = px;
        y0 = py;
        ww = 11'(1 + $urandom % (HA - px));
        hh = 11'(1 + $urandom % (VA - py));
        sh = (px <= 1 && py == 0) ? 1 : 0;
        n_pix = 0;
        ov_k = 0;
        wr(low_pkg::OFS_OVCTL, {8'h80, 2'b0, kr, 2'b0, kg, 2'b0, kb});
        wr(low_pkg::OFS_WPOS, {5'h0, y0, 5'h0, x0});
        wr(low_pkg::OFS_WSIZE, {5'h0, hh, 5'h0, ww});
        wr(low_pkg::OFS_BGBASE, bg_base);
        wr(low_pkg::OFS_OVBASE, ov_base);
        wr(low_pkg::OFS_CTRL, {30'h0, m24, 1'b1});
        for (t = 0; t < 300 && n_pix == 0; t++) @(posedge clk);
        // Cleared early: the frame must still finish, then stop
        wr(low_pkg::OFS_CTRL, {30'h0, m24, 1'b0});
        for (t = 0; t < 3000 && n_pix < NPIX; t++) @(posedge clk);
        repeat (60) @(posedge clk);
        chk("pixel count", NPIX, n_pix);
        $display("test window %0d,%0d mode24 %0d done", px, py, m24);
    endtask : frame
    // ============================================================
    // Fetch memory with random ack delays, and the pixel scoreboard
    always @(posedge clk) begin
        if (bg_ack) bg_ack <= 1'b0;
        else if (bg_req && $urandom % 2) begin
            bg_ack <= 1'b1;
            bg_data <= mem(bg_addr);
            chk("bg address", wa(bg_base, n_pix), bg_addr);
        end
        if (ov_ack) ov_ack <= 1'b0;
        else if (ov_req && $urandom % 2) begin
            ov_ack <= 1'b1;
            ov_data <= mem(ov_addr);
            chk("ov address", wa(ov_base, (sh != 0 && ov_k == 0) ?
                ww * hh - 1 : ov_k - sh), ov_addr);
            ov_k <= ov_k + 1;
        end
        if (pix_valid && pix_ready) begin
            chk("pixel", exp_pix(n_pix), pix_data);
            chk("start of frame", n_pix == 0, pix_sof);
            n_pix <= n_pix + 1;
        end
    end
    initial forever #5 clk = ~clk;
    // Watchdog well beyond the longest run
    initial begin
        #400000;
        n_mismatch++;
        close_out();
    end
    initial begin
        seed = $urandom(32'hc0374d8f);
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 8'h18; a += 4) rd_chk(8'(a), low_pkg::RST_REG);
        // Idle status after reset: only the FIFO empty bit is set
        rd_chk(low_pkg::OFS_STAT, 32'h0000_0002);
        wr(low_pkg::OFS_OVCTL, 32'hffff_ffff);
        rd_chk(low_pkg::OFS_OVCTL, 32'h803f_3f3f);
        wr(8'h1c, 32'hffff_ffff);
        rd_chk(8'h1c, 32'h0);
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            bg_base = i[0] ? 32'h1fff_ffc0 : 32'h0040_0100;
            ov_base = i[0] ? 32'h2000_0000 : 32'h203f_ffe0;
            case (i)
                0: frame(11'd0, 11'd0);
                1: frame(11'd1, 11'd0);
                2: frame(11'd2, 11'd1);
                3: frame(11'd0, 11'd1);
                default: frame(11'($urandom % HA), 11'($urandom % VA));
            endcase
        end
        close_out();
    end
endmodule : tb_top
